/* File: rtl/adcss_sweep.sv */
// A-D sweep sequencer: software start flag, channel walk, result registers.
// Assumes a comparator front end returning a 10-bit code with a done pulse.
`timescale 1ns/100ps
`include "adcss_map.svh"
module adcss_sweep
    import adcss_pkg::*;
#(
    parameter int unsigned CHANNELS = 8
)(
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire adcss_pkg::adcss_req_t busReq,
    output logic [15:0]               busRdata,
    input  wire logic [9:0]           sarCode,
    input  wire logic                 sarDone,
    output adcss_pkg::adcss_conv_t    convCtrl
);
    import adcss_pkg::*;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT} adcss_state_t;

    logic [7:0]  ctrl_r;
    logic        irq_r;
    logic [9:0]  result_r [CHANNELS];
    logic [15:0] busRdata_r;
    adcss_state_t state_r;
    logic [2:0]  chan_r;
    logic [2:0]  extra_r;
    logic        inExtra_r;
    logic [1:0]  divCnt_r;
    logic        convStart_r;
    logic        syncDone1_r;
    logic        syncDone2_r;
    logic        syncDone3_r;
    logic [9:0]  codeSync1_r;
    logic [9:0]  codeSync2_r;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire         startFlag = ctrl_r[`ADCSS_CTRL_START];
    wire adcss_mode_t mode = adcss_mode_t'(
                     ctrl_r[`ADCSS_CTRL_MODE_H:`ADCSS_CTRL_MODE_L]);
    wire [1:0]   grp       = ctrl_r[`ADCSS_CTRL_GRP_H:`ADCSS_CTRL_GRP_L];
    wire adcss_div_t div   = adcss_div_t'(
                     ctrl_r[`ADCSS_CTRL_DIV_H:`ADCSS_CTRL_DIV_L]);
    wire         res10     = ctrl_r[`ADCSS_CTRL_RES10];
    wire         wrCtrl    = busReq.wr && (busReq.addr == `ADCSS_OFF_CTRL);
    wire         wrStat    = busReq.wr && (busReq.addr == `ADCSS_OFF_STAT);
    wire         rising    = wrCtrl && busReq.wdata[`ADCSS_CTRL_START]
                             && !startFlag;
    // Last channel of the emphasised group
    wire [2:0]   lastSel   = (mode == ADCSS_MODE_REP1)
                             ? {1'b0, grp}
                             : {grp, 1'b1};
    wire         endOfGrp  = (chan_r == lastSel);
    // Next unselected channel for repeat sweep 1, wraps past seven
    wire [2:0]   extraNext = (extra_r == 3'h7)
                             ? (lastSel + 3'h1)
                             : (extra_r + 3'h1);
    wire [2:0]   extraFirst = lastSel + 3'h1;
    wire         doneEdge  = syncDone2_r && !syncDone3_r;
    wire         busy      = (state_r != ST_IDLE);

    // Divider tick for the converter clock
    // Reserved divider code runs at the slowest rate rather than stalling
    wire         divTick   = (div == ADCSS_DIV1) ? 1'b1
                           : (div == ADCSS_DIV2) ? divCnt_r[0]
                           : (divCnt_r == 2'h3);

    wire [3:0]   rdIdx     = busReq.addr - `ADCSS_OFF_RES0;
    wire [15:0]  rdMux     =
        (busReq.addr == `ADCSS_OFF_CTRL) ? {8'h00, ctrl_r} :
        (busReq.addr == `ADCSS_OFF_STAT) ?
            {9'h000, chan_r, 2'h0, busy, irq_r} :
        (busReq.addr[3] && rdIdx < 4'(CHANNELS)) ?
            (res10 ? {6'h00, result_r[rdIdx[2:0]]}
                   : {8'h00, result_r[rdIdx[2:0]][9:2]}) :
        16'h0000;

    // ------------------------------------------------------------------
    // Synchronise the analog front end
    // ------------------------------------------------------------------
    // Code passes the same two stages as done, so it is settled first
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
        begin
            syncDone1_r <= 1'b0;
            syncDone2_r <= 1'b0;
            syncDone3_r <= 1'b0;
            codeSync1_r <= 10'h000;
            codeSync2_r <= 10'h000;
        end
        else
        begin
            syncDone1_r <= sarDone;
            syncDone2_r <= syncDone1_r;
            syncDone3_r <= syncDone2_r;
            codeSync1_r <= sarCode;
            codeSync2_r <= codeSync1_r;
        end

    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            divCnt_r <= 2'h0;
        else
            divCnt_r <= divCnt_r + 2'h1;

    // ------------------------------------------------------------------
    // Control register and interrupt request
    // ------------------------------------------------------------------
    wire sweepEnd = (state_r == ST_WAIT) && doneEdge && !inExtra_r
                    && endOfGrp && (mode == ADCSS_MODE_SINGLE);
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            ctrl_r <= `ADCSS_CTRL_RST;
        else if (wrCtrl)
            ctrl_r <= busReq.wdata[7:0];
        else if (sweepEnd)
            ctrl_r[`ADCSS_CTRL_START] <= 1'b0;

    // Set wins over software clear
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            irq_r <= 1'b0;
        else if (sweepEnd)
            irq_r <= 1'b1;
        else if (wrStat && !busReq.wdata[`ADCSS_STAT_IRQ])
            irq_r <= 1'b0;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // A clear written in this very cycle already counts as stopped, so no
    // conversion slips out on the edge that takes the write
    wire         stopWr    = wrCtrl && !busReq.wdata[`ADCSS_CTRL_START];
    wire         runOn     = startFlag && !stopWr;
    wire         takeExtra = (mode == ADCSS_MODE_REP1)
                             && (lastSel != 3'h7);
    wire [2:0]   extraPick = (extra_r < extraFirst) ? extraFirst
                                                    : extraNext;

    adcss_state_t state_nxt;
    logic [2:0]   chan_nxt;
    logic [2:0]   extra_nxt;
    logic         inExtra_nxt;
    logic         convStart_nxt;

    always_comb
    begin
        state_nxt     = state_r;
        chan_nxt      = chan_r;
        extra_nxt     = extra_r;
        inExtra_nxt   = inExtra_r;
        convStart_nxt = 1'b0;
        case (state_r)
            ST_IDLE:
                if (rising)
                begin
                    chan_nxt    = 3'h0;
                    extra_nxt   = 3'h7;
                    inExtra_nxt = 1'b0;
                    state_nxt   = ST_CONV;
                end
            ST_CONV:
                if (!runOn)
                    state_nxt = ST_IDLE;
                else if (divTick)
                begin
                    convStart_nxt = 1'b1;
                    state_nxt     = ST_WAIT;
                end
            ST_WAIT:
                if (doneEdge)
                begin
                    state_nxt = ST_CONV;
                    if (!runOn)
                        state_nxt = ST_IDLE;
                    else if (inExtra_r)
                    begin
                        inExtra_nxt = 1'b0;
                        chan_nxt    = 3'h0;
                    end
                    else if (!endOfGrp)
                        chan_nxt = chan_r + 3'h1;
                    else if (mode == ADCSS_MODE_SINGLE)
                        state_nxt = ST_IDLE;
                    else if (takeExtra)
                    begin
                        inExtra_nxt = 1'b1;
                        extra_nxt   = extraPick;
                        chan_nxt    = extraPick;
                    end
                    else
                        chan_nxt = 3'h0;
                end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
        begin
            state_r     <= ST_IDLE;
            chan_r      <= 3'h0;
            extra_r     <= 3'h0;
            inExtra_r   <= 1'b0;
            convStart_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            chan_r      <= chan_nxt;
            extra_r     <= extra_nxt;
            inExtra_r   <= inExtra_nxt;
            convStart_r <= convStart_nxt;
        end

    // ------------------------------------------------------------------
    // Result registers; one per channel
    // ------------------------------------------------------------------
    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_res
        always_ff @(posedge sys_clk or negedge reset_n)
            if (!reset_n)
                result_r[i] <= 10'h000;
            else if (state_r == ST_WAIT && doneEdge && chan_r == 3'(i))
                result_r[i] <= codeSync2_r;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            busRdata_r <= 16'h0000;
        else
            busRdata_r <= busReq.rd ? rdMux : 16'h0000;

    assign busRdata         = busRdata_r;
    assign convCtrl.channel = chan_r;
    assign convCtrl.res10   = ctrl_r[`ADCSS_CTRL_RES10];
    assign convCtrl.start   = convStart_r;

endmodule // adcss_sweep

/* File: rtl/adcss_map.svh */
// Register offsets, field positions and timing counts of the sweep sequencer.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ADCSS_MAP_SVH
`define ADCSS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define ADCSS_OFF_CTRL    4'h0
`define ADCSS_OFF_STAT    4'h1
`define ADCSS_OFF_RES0    4'h8

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ADCSS_CTRL_START  0
`define ADCSS_CTRL_MODE_L 1
`define ADCSS_CTRL_MODE_H 2
`define ADCSS_CTRL_GRP_L  3
`define ADCSS_CTRL_GRP_H  4
`define ADCSS_CTRL_DIV_L  5
`define ADCSS_CTRL_DIV_H  6
`define ADCSS_CTRL_RES10  7
`define ADCSS_CTRL_RST    8'h00

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define ADCSS_STAT_IRQ    0
`define ADCSS_STAT_BUSY   1
`define ADCSS_STAT_CH_L   4
`define ADCSS_STAT_CH_H   6

// ----------------------------------------------------------------------
// Conversion timing in converter clock ticks (10-bit and 8-bit)
// ----------------------------------------------------------------------
`define ADCSS_TICKS_10    6'h21
`define ADCSS_TICKS_8     6'h1c

`endif

/* File: rtl/adcss_pkg.sv */
// Types shared by the sweep sequencer and its bench.
// Assumes the constant map header is on the include path.
package adcss_pkg;
    `include "adcss_map.svh"

    typedef enum logic [1:0] {
        ADCSS_MODE_SINGLE = 2'h0,
        ADCSS_MODE_REP0   = 2'h1,
        ADCSS_MODE_REP1   = 2'h2,
        ADCSS_MODE_RSVD   = 2'h3
    } adcss_mode_t;

    typedef enum logic [1:0] {
        ADCSS_DIV4 = 2'h0,
        ADCSS_DIV2 = 2'h1,
        ADCSS_DIV1 = 2'h2,
        ADCSS_DIVX = 2'h3
    } adcss_div_t;

    // Register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } adcss_req_t;

    // Analog front-end handshake
    typedef struct packed {
        logic [2:0] channel;
        logic       res10;
        logic       start;
    } adcss_conv_t;
endpackage

/* File: dv/adcss_front_model.sv */
// Analog front end model: answers each start pulse with a code.
// Assumes the sequencer keeps one request open at a time.
`timescale 1ns/100ps
module adcss_front_model
    import adcss_pkg::*;
(
    input  wire adcss_pkg::adcss_conv_t convCtrl,
    input  wire logic                   sys_clk,
    input  wire logic [6:0]             salt,
    input  wire logic [3:0]             lag,
    output logic [9:0]                  sarCode,
    output logic                        sarDone
);
    logic [2:0] ch;
    initial
    begin
        sarCode = 10'h2aa;
        sarDone = 1'b0;
        forever
        begin
            // Sampled off the edge so the pulse is settled
            @(negedge sys_clk);
            if (convCtrl.start)
            begin
                ch = convCtrl.channel;
                repeat (lag + 1) @(posedge sys_clk);
                sarCode <= {ch, salt};
                @(posedge sys_clk);
                sarDone <= 1'b1;
                repeat (3) @(posedge sys_clk);
                sarDone <= 1'b0;
                // Stale code is inverted, never left looking valid
                sarCode <= ~{ch, salt};
            end
        end
    end
endmodule // adcss_front_model

/* File: dv/adcss_sweep_assertions.sv */
// Port checker of the sweep sequencer, attached by bind.
// Assumes setup changes only while the sequencer is stopped.
`timescale 1ns/100ps
`include "adcss_map.svh"
module adcss_sweep_assertions
    import adcss_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   reset_n,
    input wire adcss_pkg::adcss_req_t  busReq,
    input wire logic [15:0]            busRdata,
    input wire logic [9:0]             sarCode,
    input wire logic                   sarDone,
    input wire adcss_pkg::adcss_conv_t convCtrl
);
    // ------------------------------------------------------------------
    // Shadow of the sweep setup
    // ------------------------------------------------------------------
    logic [1:0] mode_r;
    logic [1:0] grp_r;
    logic [2:0] prev_r;
    logic [2:0] extra_r;
    wire logic setWr = busReq.wr && busReq.addr == `ADCSS_OFF_CTRL;
    wire logic rep1 = mode_r == ADCSS_MODE_REP1;
    wire logic go = convCtrl.start;
    wire logic [2:0] ch = convCtrl.channel;
    wire logic [2:0] grp3 = {1'b0, grp_r};
    wire logic [2:0] nextX = (extra_r == 3'h7) ? grp3 + 3'h1 : extra_r + 3'h1;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_r  <= 2'h0;
            grp_r   <= 2'h0;
            prev_r  <= 3'h7;
            extra_r <= 3'h7;
        end
        else if (setWr)
        begin
            mode_r <= busReq.wdata[2:1];
            grp_r  <= busReq.wdata[4:3];
            // Seven makes the first step of a sweep land on zero
            if (busReq.wdata[0])
            begin
                prev_r  <= 3'h7;
                extra_r <= 3'h7;
            end
        end
        else if (go)
        begin
            prev_r <= ch;
            if (rep1 && ch > grp3)
                extra_r <= ch;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    start_pulse_a:
        assert property (go |=> !go) else $error("start pulse too long");
    sweep_order_a:
        assert property (go && !rep1 |-> ch == ((prev_r == {grp_r, 1'b1}) ?
            3'h0 : prev_r + 3'h1)) else $error("sweep channel order wrong");
    rep1_pass_a:
        assert property (go && rep1 && prev_r != grp3 |-> ch == ((prev_r >
            grp3) ? 3'h0 : prev_r + 3'h1)) else $error("pass order wrong");
    rep1_extra_a:
        assert property (go && rep1 && prev_r == grp3 |-> ch == nextX)
        else $error("unselected channel wrong");
    chan_hold_a:
        assert property (go |=> $stable(ch)[*2]) else $error("channel moved");
    first_start_a:
        assert property (setWr && busReq.wdata[0] |-> ##[1:6] go && ch == 3'h0)
        else $error("sweep did not start at channel zero");
    stop_clear_a:
        assert property (setWr && !busReq.wdata[0] |=> !go [*8])
        else $error("conversion after start cleared");
    res_follow_a:
        assert property (setWr |=> convCtrl.res10 == $past(busReq.wdata[7]))
        else $error("resolution not followed");
    cover property (go && rep1 && ch > grp3);
    cover property (setWr && busReq.wdata[0]);
    cover property ($rose(sarDone));
endmodule // adcss_sweep_assertions
bind adcss_sweep adcss_sweep_assertions u_chk (.sys_clk(sys_clk),
    .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata),
    .sarCode(sarCode), .sarDone(sarDone), .convCtrl(convCtrl));

/* File: dv/tb.sv */
// Self-checking bench of the sweep sequencer over its register port.
// Assumes the front end model and the bound checker are compiled first.
`timescale 1ns/100ps
`include "adcss_map.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    import adcss_pkg::*;
    localparam logic [3:0] CT = `ADCSS_OFF_CTRL;
    localparam logic [3:0] ST = `ADCSS_OFF_STAT;
    localparam logic [3:0] RS = `ADCSS_OFF_RES0;
    logic sys_clk, reset_n, sarDone;
    adcss_req_t busReq;
    adcss_conv_t convCtrl;
    logic [15:0] busRdata, rv;
    logic [9:0] sarCode;
    logic [6:0] salt;
    logic [3:0] lag;
    int error_cnt, total_checks;
    adcss_sweep #(.CHANNELS(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .busReq(busReq), .busRdata(busRdata), .sarCode(sarCode),
        .sarDone(sarDone), .convCtrl(convCtrl));
    adcss_front_model u_front (.convCtrl(convCtrl), .sys_clk(sys_clk),
        .salt(salt), .lag(lag), .sarCode(sarCode), .sarDone(sarDone));
    function automatic logic [15:0] cw(logic [1:0] m, logic [1:0] g,
                                       logic [1:0] d, logic r, logic s);
        return {8'h0, r, d, g, m, s};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        busReq <= '0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        busReq <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        busReq <= '0;
        @(negedge sys_clk);
        rv = busRdata;
        @(posedge sys_clk);
    endtask
    task automatic chk(string n, logic [3:0] a, logic [15:0] m, e);
        rd(a);
        `CHK(n, e, rv & m)
    endtask
    task automatic poll(logic [3:0] a, logic [15:0] m, e);
        int k;
        rd(a);
        for (k = 0; k < 500 && (rv & m) !== e; k++)
            rd(a);
        if (k == 500)
        begin
            `CHK("poll", e, rv & m)
            close_out();
        end
    endtask
    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        {reset_n, busReq, salt, lag, error_cnt, total_checks} = '0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        // No key-input interrupts here: channels four to seven are free
        // Bus master runs on the undivided clock in every mode
        chk("ctrl", CT, 16'hffff, 16'h0);
        chk("stat", ST, 16'h0003, 16'h0);
        wr(4'h5, 16'hffff);
        chk("unmapped", 4'h5, 16'hffff, 16'h0);
        for (int g = 0; g < 4; g++)
        begin
            salt <= 7'h05 + 7'(g * 17);
            lag <= 4'(g * 3);
            wr(CT, cw(2'h0, 2'h0, 2'(g % 3), 1'b1, 1'b0));
            repeat (40) @(posedge sys_clk);
            wr(CT, cw(2'h0, 2'(g), 2'(g % 3), 1'b1, 1'b1));
            poll(ST, 16'h0001, 16'h0001);
            chk("stop", ST, 16'h0003, 16'h0001);
            chk("start", CT, 16'h0001, 16'h0);
            for (int c = 0; c <= 2 * g + 1; c++)
                chk("res", RS + 4'(c), 16'hffff, {6'h0, 3'(c), salt});
            wr(ST, 16'h0);
            chk("irq", ST, 16'h0001, 16'h0);
        end
        salt <= 7'h2a;
        // Fast divider settings stand in for a slow converter source
        wr(CT, cw(2'h1, 2'h0, 2'h2, 1'b0, 1'b0));
        wr(CT, cw(2'h1, 2'h1, 2'h2, 1'b0, 1'b1));
        poll(RS + 4'h3, 16'hffff, 16'h006a);
        salt <= 7'h55;
        for (int c = 0; c < 4; c++)
            poll(RS + 4'(c), 16'hffff, {8'h0, 3'(c), 5'h15});
        chk("rep0", ST, 16'h0003, 16'h0002);
        wr(CT, cw(2'h1, 2'h1, 2'h2, 1'b0, 1'b0));
        poll(ST, 16'h0002, 16'h0);
        salt <= 7'h4d;
        lag <= 4'h2;
        wr(CT, cw(2'h2, 2'h0, 2'h1, 1'b1, 1'b0));
        wr(CT, cw(2'h2, 2'h1, 2'h1, 1'b1, 1'b1));
        for (int c = 0; c < 8; c++)
            poll(RS + 4'(c), 16'hffff, {6'h0, 3'(c), 7'h4d});
        chk("rep1", ST, 16'h0003, 16'h0002);
        wr(CT, cw(2'h2, 2'h1, 2'h1, 1'b1, 1'b0));
        poll(ST, 16'h0002, 16'h0);
        chk("res2", RS + 4'h2, 16'hffff, 16'h014d);
        close_out();
    end
endmodule // tb
